// ===== core/afd_agen.sv
// Combinational data address generator.
// Assumes pointers and bank pointer come from registers of the caller.
`timescale 1ns/1ps
`default_nettype none
module afd_agen
  import afd_pkg::*;
(
  // Request
  input  wire afd_pkg::afd_req_t req,
  input  wire logic [3:0]        bank,
  input  wire logic [11:0]       ptr_sel,
  input  wire logic [11:0]       ptr2,
  input  wire logic [7:0]        acc,
  input  wire logic              ext_ops,
  // Address and pointer step
  output logic [11:0]            addr,
  output logic [11:0]            ptr_next,
  output logic                   ptr_write
);
  import afd_pkg::*;

  always_comb
  begin
    addr      = 12'h000;
    ptr_next  = ptr_sel;
    ptr_write = 1'b0;
    case (req.amode)
      AFD_AM_DIRECT:
      begin
        if (req.bank_sel)
          addr = {bank, req.literal};
        else if (ext_ops && req.literal <= AFD_OFFSET_MAX)
          addr = ptr2 + {4'h0, req.literal};
        else if (req.literal >= AFD_QUICK_SPLIT)
          addr = {AFD_QUICK_HIGH, req.literal};
        else
          addr = {4'h0, req.literal};
      end
      AFD_AM_FULL: addr = req.full_addr;
      AFD_AM_INDIRECT:
      begin
        addr = ptr_sel;
        case (req.vop)
          AFD_VP_POST_INC:
          begin
            ptr_next  = ptr_sel + 12'h001;
            ptr_write = 1'b1;
          end
          AFD_VP_POST_DEC:
          begin
            ptr_next  = ptr_sel - 12'h001;
            ptr_write = 1'b1;
          end
          AFD_VP_ACC_OFS: addr = ptr_sel + {{4{acc[7]}}, acc};
          default: ptr_write = 1'b0;
        endcase
      end
      default: addr = 12'h000;
    endcase
  end

endmodule : afd_agen
`default_nettype wire

// ===== core/afd_alu.sv
// Combinational ALU with flag generation.
// Assumes operands are registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module afd_alu
  import afd_pkg::*;
(
  // Operation
  input  wire afd_pkg::afd_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       file,
  input  wire logic [7:0]       literal,
  input  wire logic [2:0]       bit_idx,
  input  wire logic [7:0]       flags_in,
  // Result
  output logic [7:0]            result,
  output logic [4:0]            flags_out,
  output logic [4:0]            flags_touch
);
  import afd_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] a;
  logic [7:0] b;

  always_comb
  begin
    a           = acc;
    b           = file;
    sum         = 9'h000;
    low         = 5'h00;
    result      = 8'h00;
    flags_out   = flags_in[4:0];
    flags_touch = 5'h00;
    case (op)
      AFD_OP_ADD_FILE, AFD_OP_ADD_LIT, AFD_OP_SUB_FILE, AFD_OP_SUB_LIT:
      begin
        // Subtract adds the two's complement, so carry means no borrow
        if (op == AFD_OP_ADD_LIT || op == AFD_OP_SUB_LIT)
          b = literal;
        if (op == AFD_OP_SUB_FILE)
        begin
          a = file;
          b = acc;
        end
        if (op == AFD_OP_SUB_LIT)
        begin
          a = literal;
          b = acc;
        end
        if (op == AFD_OP_SUB_FILE || op == AFD_OP_SUB_LIT)
        begin
          sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
          low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        end
        else
        begin
          sum = {1'b0, a} + {1'b0, b};
          low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        end
        result = sum[7:0];
        flags_out[AFD_BIT_HWRAP] = low[4];
        flags_out[AFD_BIT_RWRAP] = sum[8];
        flags_out[AFD_BIT_SWRAP] = (a[7] == (b[7] ^ (op == AFD_OP_SUB_FILE
                                   || op == AFD_OP_SUB_LIT))) && (sum[7] != a[7]);
        flags_touch = AFD_ARITH_MASK;
      end
      AFD_OP_AND:
      begin
        result = acc & file;
        flags_touch = 5'h14;
      end
      AFD_OP_CLEAR:
      begin
        result = 8'h00;
        flags_touch = 5'h04;
      end
      AFD_OP_ROT_RIGHT:
      begin
        result = {flags_in[AFD_BIT_RWRAP], file[7:1]};
        flags_out[AFD_BIT_RWRAP] = file[0];
        flags_out[AFD_BIT_HWRAP] = file[4];
        flags_touch = 5'h17;
      end
      AFD_OP_ROT_LEFT:
      begin
        result = {file[6:0], flags_in[AFD_BIT_RWRAP]};
        flags_out[AFD_BIT_RWRAP] = file[7];
        flags_out[AFD_BIT_HWRAP] = file[3];
        flags_touch = 5'h17;
      end
      // Flag-neutral operations
      AFD_OP_BIT_CLEAR: result = file & ~(8'h01 << bit_idx);
      AFD_OP_BIT_SET:   result = file | (8'h01 << bit_idx);
      AFD_OP_SWAP:      result = {file[3:0], file[7:4]};
      AFD_OP_MOVE_FULL: result = file;
      AFD_OP_ACC_TO_FILE: result = acc;
      default: result = 8'h00;
    endcase
    if (flags_touch[AFD_BIT_NULL])
      flags_out[AFD_BIT_NULL] = (result == 8'h00);
    if (flags_touch[AFD_BIT_BELOW])
      flags_out[AFD_BIT_BELOW] = result[7];
  end

endmodule : afd_alu
`default_nettype wire

// ===== core/afd_core.sv
// Flag register, pointers and operand addressing of the processor core.
// Assumes an APB master for software access and a decoder giving one request per cycle.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module afd_core
  import afd_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Decoder request
  input  wire afd_pkg::afd_req_t req,
  // Answer to data memory
  output afd_pkg::afd_rsp_t     rsp,
  output logic [7:0]            alu_flags_out
);
  import afd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]       flags;
    logic [3:0]       bank;
    logic [2:0][11:0] ptr;
    logic [7:0]       acc;
    logic             ext_ops;
    logic             apb_done;
    logic [31:0]      rdata;
    logic             slverr;
    afd_rsp_t         rsp;
  } afd_state_t;

  afd_state_t st_q;
  afd_state_t st_d;

  logic [7:0]  alu_result;
  logic [4:0]  alu_flags;
  logic [4:0]  alu_touch;
  logic [11:0] ag_addr;
  logic [11:0] ag_ptr_next;
  logic        ag_ptr_write;

  function automatic logic [31:0] afd_read(input afd_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      AFD_OFS_FLAGS: v = {24'h0, 3'h0, s.flags[4:0]};
      AFD_OFS_BANK:  v = {28'h0, s.bank};
      AFD_OFS_PTR0:  v = {20'h0, s.ptr[0]};
      AFD_OFS_PTR1:  v = {20'h0, s.ptr[1]};
      AFD_OFS_PTR2:  v = {20'h0, s.ptr[2]};
      AFD_OFS_ACC:   v = {24'h0, s.acc};
      AFD_OFS_CFG:   v = {31'h0, s.ext_ops};
      AFD_OFS_ADDR:  v = {20'h0, s.rsp.addr};
      default:       v = 32'h0000_0000;
    endcase
    return v;
  endfunction : afd_read

  function automatic logic afd_mapped(input logic [7:0] a);
    return (a <= AFD_OFS_ADDR) && (a[1:0] == 2'b00);
  endfunction : afd_mapped

  // ****************************************************************
  // Datapath
  // ****************************************************************
  afd_alu u_alu (
    .op          (req.op),
    .acc         (st_q.acc),
    .file        (req.file_data),
    .literal     (req.literal),
    .bit_idx     (req.bit_idx),
    .flags_in    (st_q.flags),
    .result      (alu_result),
    .flags_out   (alu_flags),
    .flags_touch (alu_touch)
  );

  afd_agen u_agen (
    .req       (req),
    .bank      (st_q.bank),
    .ptr_sel   (st_q.ptr[(req.ptr_idx > 2'd2) ? 2'd2 : req.ptr_idx]),
    .ptr2      (st_q.ptr[2]),
    .acc       (st_q.acc),
    .ext_ops   (st_q.ext_ops),
    .addr      (ag_addr),
    .ptr_next  (ag_ptr_next),
    .ptr_write (ag_ptr_write)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [1:0] pidx;
  logic       to_flags;
  logic       to_file;
  logic [7:0] wv;

  always_comb
  begin
    st_d     = st_q;
    pidx     = (req.ptr_idx > 2'd2) ? 2'd2 : req.ptr_idx;
    to_flags = 1'b0;
    to_file  = 1'b0;
    wv       = 8'h00;
    st_d.rsp.valid = 1'b0;
    st_d.rsp.wr_acc = 1'b0;
    st_d.rsp.wr_file = 1'b0;

    // APB: answer after one wait state in the access phase
    st_d.apb_done = 1'b0;
    if (psel && !penable)
    begin
      st_d.rdata  = afd_read(st_q, paddr);
      st_d.slverr = !afd_mapped(paddr);
    end
    if (psel && penable)
      st_d.apb_done = !st_q.apb_done;
    // Write lands at the edge where the master samples pready high
    if (psel && penable && st_q.apb_done)
    begin
      if (pwrite && afd_mapped(paddr))
      begin
        case (paddr)
          AFD_OFS_FLAGS: st_d.flags = {3'h0, pwdata[4:0]};
          AFD_OFS_BANK:  st_d.bank = pwdata[3:0];
          AFD_OFS_PTR0:  st_d.ptr[0] = pwdata[11:0];
          AFD_OFS_PTR1:  st_d.ptr[1] = pwdata[11:0];
          AFD_OFS_PTR2:  st_d.ptr[2] = pwdata[11:0];
          AFD_OFS_ACC:   st_d.acc = pwdata[7:0];
          AFD_OFS_CFG:   st_d.ext_ops = pwdata[0];
          default:       st_d.acc = st_q.acc;
        endcase
      end
    end

    // Execute: instruction wins over a bus write in the same cycle
    if (req.valid)
    begin
      st_d.rsp.valid     = 1'b1;
      st_d.rsp.addr      = ag_addr;
      st_d.rsp.result    = alu_result;
      st_d.rsp.prog_addr = (req.amode == AFD_AM_LITERAL) ?
                           {req.full_addr, req.literal} : 20'h00000;
      case (req.op)
        AFD_OP_NONE: to_file = 1'b0;
        AFD_OP_ADD_LIT, AFD_OP_SUB_LIT: st_d.rsp.wr_acc = 1'b1;
        AFD_OP_BIT_CLEAR, AFD_OP_BIT_SET, AFD_OP_CLEAR, AFD_OP_MOVE_FULL,
        AFD_OP_ACC_TO_FILE: to_file = 1'b1;
        default:
        begin
          to_file         = req.to_source;
          st_d.rsp.wr_acc = !req.to_source;
        end
      endcase
      st_d.rsp.wr_file = to_file;
      if (st_d.rsp.wr_acc)
        st_d.acc = alu_result;
      to_flags = to_file && (ag_addr == AFD_FLAGS_ADDR);
      wv = st_q.flags;
      // A flag-setting op blocks the whole five-bit write; neutral ops write through
      if (to_flags && alu_touch == 5'h00)
        wv = alu_result & 8'h1f;
      else if (to_flags)
        wv = st_q.flags;
      // Hardware-produced flags override the stored write
      st_d.flags = {3'h0, (wv[4:0] & ~alu_touch) | (alu_flags & alu_touch)};
      if (ag_ptr_write)
        st_d.ptr[pidx] = ag_ptr_next;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q          <= '0;
      st_q.flags    <= AFD_FLAGS_RST;
      st_q.bank     <= AFD_BANK_RST;
      st_q.ptr      <= {3{AFD_PTR_RST}};
      st_q.acc      <= AFD_ACC_RST;
    end
    else if (clk_en)
      st_q <= st_d;
  end

  assign prdata        = st_q.rdata;
  assign pslverr       = st_q.slverr & st_q.apb_done;
  assign pready        = st_q.apb_done;
  assign rsp           = st_q.rsp;
  assign alu_flags_out = st_q.flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  upper_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    st_q.flags[7:5] == 3'h0) else $error("flag upper bits set");

  null_flag_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == AFD_OP_AND |=>
      st_q.flags[AFD_BIT_NULL] == (st_q.rsp.result == 8'h00)) else $error("null flag wrong");

  below_flag_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == AFD_OP_ADD_LIT |=>
      st_q.flags[AFD_BIT_BELOW] == st_q.rsp.result[7]) else $error("below flag wrong");

  neutral_ops_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && (req.op == AFD_OP_SWAP || req.op == AFD_OP_MOVE_FULL)
      && !(req.to_source || req.op == AFD_OP_MOVE_FULL) |=>
      st_q.flags == $past(st_q.flags)) else $error("neutral op changed flags");

  clear_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == AFD_OP_CLEAR && ag_addr == AFD_FLAGS_ADDR |=>
      st_q.flags == ($past(st_q.flags) | 8'h04)) else $error("clear on flags wrong");

  post_inc_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.amode == AFD_AM_INDIRECT && req.vop == AFD_VP_POST_INC
      && req.ptr_idx == 2'd0 && !psel |=>
      st_q.ptr[0] == $past(st_q.ptr[0]) + 12'h001) else $error("post increment wrong");

  acc_ofs_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.amode == AFD_AM_INDIRECT && req.vop == AFD_VP_ACC_OFS
      && !psel && !st_d.rsp.wr_acc |=>
      st_q.ptr == $past(st_q.ptr) && st_q.acc == $past(st_q.acc)) else $error("offset changed state");

  full_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.amode == AFD_AM_FULL |=>
      st_q.rsp.addr == $past(req.full_addr)) else $error("full address wrong");

  bank_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.amode == AFD_AM_DIRECT && req.bank_sel |=>
      st_q.rsp.addr == {$past(st_q.bank), $past(req.literal)}) else $error("bank address wrong");

  dest_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    clk_en && req.valid && req.op == AFD_OP_AND |=>
      st_q.rsp.wr_file == $past(req.to_source) && st_q.rsp.wr_acc == !$past(req.to_source))
    else $error("destination wrong");

endmodule : afd_core
`default_nettype wire

// ===== core/afd_pkg.sv
// Shared types and constants of the ALU flag and data addressing slice.
// Assumes one core clock; the decoder supplies one operation per execute cycle.
package afd_pkg;

  // ****************************************************************
  // Register map (APB, byte addresses)
  // ****************************************************************
  localparam logic [7:0] AFD_OFS_FLAGS   = 8'h00;
  localparam logic [7:0] AFD_OFS_BANK    = 8'h04;
  localparam logic [7:0] AFD_OFS_PTR0    = 8'h08;
  localparam logic [7:0] AFD_OFS_PTR1    = 8'h0c;
  localparam logic [7:0] AFD_OFS_PTR2    = 8'h10;
  localparam logic [7:0] AFD_OFS_ACC     = 8'h14;
  localparam logic [7:0] AFD_OFS_CFG     = 8'h18;
  localparam logic [7:0] AFD_OFS_ADDR    = 8'h1c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         AFD_BIT_BELOW   = 4;
  localparam int         AFD_BIT_SWRAP   = 3;
  localparam int         AFD_BIT_NULL    = 2;
  localparam int         AFD_BIT_HWRAP   = 1;
  localparam int         AFD_BIT_RWRAP   = 0;
  localparam logic [4:0] AFD_ARITH_MASK  = 5'h1f;
  localparam logic [7:0] AFD_FLAGS_RST   = 8'h00;
  localparam logic [3:0] AFD_BANK_RST    = 4'h0;
  localparam logic [11:0] AFD_PTR_RST    = 12'h000;
  localparam logic [7:0] AFD_ACC_RST     = 8'h00;
  localparam logic [7:0] AFD_QUICK_SPLIT = 8'h60;
  localparam logic [3:0] AFD_QUICK_HIGH  = 4'hf;
  localparam logic [7:0] AFD_OFFSET_MAX  = 8'h5f;
  localparam logic [11:0] AFD_FLAGS_ADDR = 12'hfd8;

  // ****************************************************************
  // Operations and addressing
  // ****************************************************************
  typedef enum logic [3:0] {
    AFD_OP_NONE, AFD_OP_ADD_FILE, AFD_OP_ADD_LIT, AFD_OP_SUB_FILE,
    AFD_OP_SUB_LIT, AFD_OP_AND, AFD_OP_CLEAR, AFD_OP_ROT_RIGHT,
    AFD_OP_ROT_LEFT, AFD_OP_BIT_CLEAR, AFD_OP_BIT_SET, AFD_OP_SWAP,
    AFD_OP_MOVE_FULL, AFD_OP_ACC_TO_FILE
  } afd_op_t;

  typedef enum logic [2:0] {
    AFD_AM_INHERENT, AFD_AM_LITERAL, AFD_AM_DIRECT, AFD_AM_FULL,
    AFD_AM_INDIRECT
  } afd_amode_t;

  typedef enum logic [1:0] {
    AFD_VP_PLAIN, AFD_VP_POST_INC, AFD_VP_POST_DEC, AFD_VP_ACC_OFS
  } afd_vop_t;

  // Decoder request for one execute cycle
  typedef struct packed {
    logic       valid;
    afd_op_t    op;
    afd_amode_t amode;
    logic       bank_sel;
    logic       to_source;
    logic [7:0] literal;
    logic [11:0] full_addr;
    logic [1:0] ptr_idx;
    afd_vop_t   vop;
    logic [2:0] bit_idx;
    logic [7:0] file_data;
  } afd_req_t;

  // Answer towards data memory and decoder
  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic        wr_acc;
    logic        wr_file;
    logic [7:0]  result;
    logic [19:0] prog_addr;
  } afd_rsp_t;

endpackage : afd_pkg

// ===== sim/afd_dec_model.sv
// Decoder and data memory model: one request per execute cycle.
// Assumes the core takes req at the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module afd_dec_model
  import afd_pkg::*;
(
  // Clock
  input  wire logic             clock,
  // Request
  output var afd_pkg::afd_req_t req
);
  import afd_pkg::*;
  initial req = '0;
  // Released fields show the inverse, so a stale value never passes for a request
  task automatic send(input afd_req_t r);
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= {1'b0, ~r[$bits(afd_req_t)-2:0]};
  endtask : send
endmodule : afd_dec_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench of the flag and addressing slice.
// Assumes one-cycle answers to requests and one APB wait state.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import afd_pkg::*;
  // ****************
  // Harness
  // ****************
  logic        clock   = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  afd_req_t    req, r;
  afd_rsp_t    rsp;
  logic [7:0]  flags;
  int          errors   = 0;
  int          compares = 0;
  always #25 clock = ~clock;
  afd_dec_model dec_u (.clock(clock), .req(req));
  afd_core dut_u (.clock(clock), .rstn(rstn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .rsp(rsp),
    .alu_flags_out(flags));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic afd_req_t mk(afd_op_t o, afd_amode_t m, logic [7:0] l, logic [7:0] f);
    afd_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.op = o;
    q.amode = m;
    q.literal = l;
    q.file_data = f;
    return q;
  endfunction : mk
  task automatic go(input afd_req_t q);
    dec_u.send(q);
    #1;
    chk("rsp_valid", rsp.valid, 1'b1);
  endtask : go
  task automatic t_regs;
    chk("flags_rst", flags, 8'h00);
    apb(1'b1, AFD_OFS_FLAGS, 32'hffffffff);
    apb(1'b0, AFD_OFS_FLAGS, 32'h0);
    chk("flags_hi", rd, 32'h1f);
    apb(1'b1, AFD_OFS_PTR0, 32'hffffffff);
    apb(1'b0, AFD_OFS_PTR0, 32'h0);
    chk("ptr_width", rd, 32'hfff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", er, 1'b1);
  endtask : t_regs
  task automatic t_arith;
    apb(1'b1, AFD_OFS_ACC, 32'h7f);
    go(mk(AFD_OP_ADD_LIT, AFD_AM_LITERAL, 8'h01, 8'h00));
    chk("add_res", rsp.result, 8'h80);
    chk("add_flags", flags, 8'h1a);
    go(mk(AFD_OP_ADD_LIT, AFD_AM_LITERAL, 8'h80, 8'h00));
    chk("wrap_flags", flags, 8'h0d);
    apb(1'b1, AFD_OFS_ACC, 32'h03);
    go(mk(AFD_OP_SUB_LIT, AFD_AM_LITERAL, 8'h05, 8'h00));
    chk("sub_res", rsp.result, 8'h02);
    chk("sub_flags", flags, 8'h03);
    go(mk(AFD_OP_SUB_LIT, AFD_AM_LITERAL, 8'h01, 8'h00));
    chk("borrow", flags, 8'h10);
    go(mk(AFD_OP_SUB_FILE, AFD_AM_DIRECT, 8'h20, 8'h10));
    chk("subf_res", rsp.result, 8'h11);
    chk("subf_flags", flags, 8'h00);
    go(mk(AFD_OP_ROT_RIGHT, AFD_AM_DIRECT, 8'h10, 8'h01));
    chk("rot_r", flags[1:0], 2'b01);
    go(mk(AFD_OP_ROT_LEFT, AFD_AM_DIRECT, 8'h10, 8'h08));
    chk("rot_l", flags[1:0], 2'b10);
  endtask : t_arith
  task automatic t_flag_reg;
    afd_op_t ops[5] = '{AFD_OP_BIT_CLEAR, AFD_OP_BIT_SET, AFD_OP_SWAP,
                        AFD_OP_MOVE_FULL, AFD_OP_ACC_TO_FILE};
    apb(1'b1, AFD_OFS_FLAGS, 32'h19);
    r = mk(AFD_OP_CLEAR, AFD_AM_DIRECT, AFD_FLAGS_ADDR[7:0], 8'h19);
    r.to_source = 1'b1;
    go(r);
    chk("clr_addr", rsp.addr, AFD_FLAGS_ADDR);
    chk("clr_flags", flags, 8'h1d);
    // Zero data would set the null flag if bit clear, swap or move full touched it
    apb(1'b1, AFD_OFS_FLAGS, 32'h0a);
    foreach (ops[i])
    begin
      r = mk(ops[i], AFD_AM_DIRECT, 8'h10, 8'h00);
      if (ops[i] == AFD_OP_MOVE_FULL)
        r.amode = AFD_AM_FULL;
      r.full_addr = 12'h010;
      r.to_source = 1'b1;
      go(r);
      chk("keep_flags", flags, 8'h0a);
    end
  endtask : t_flag_reg
  task automatic t_addr;
    apb(1'b1, AFD_OFS_BANK, 32'h3);
    r = mk(AFD_OP_ADD_FILE, AFD_AM_DIRECT, 8'h45, 8'h00);
    r.bank_sel = 1'b1;
    r.to_source = 1'b1;
    go(r);
    chk("bank_addr", rsp.addr, 12'h345);
    chk("to_file", {rsp.wr_file, rsp.wr_acc}, 2'b10);
    r.bank_sel = 1'b0;
    r.to_source = 1'b0;
    go(r);
    chk("quick_lo", rsp.addr, 12'h045);
    chk("to_acc", {rsp.wr_file, rsp.wr_acc}, 2'b01);
    r.literal = 8'h80;
    go(r);
    chk("quick_hi", rsp.addr, 12'hf80);
    r = mk(AFD_OP_AND, AFD_AM_DIRECT, 8'h10, 8'h0f);
    go(r);
    chk("and_res", rsp.result, 8'h01);
    chk("and_dest", {rsp.wr_file, rsp.wr_acc}, 2'b01);
    r = mk(AFD_OP_MOVE_FULL, AFD_AM_FULL, 8'h00, 8'h00);
    r.full_addr = 12'h9ab;
    r.bank_sel = 1'b1;
    go(r);
    chk("full_addr", rsp.addr, 12'h9ab);
    r = mk(AFD_OP_NONE, AFD_AM_LITERAL, 8'hde, 8'h00);
    r.full_addr = 12'habc;
    go(r);
    chk("prog_addr", rsp.prog_addr, 20'habcde);
  endtask : t_addr
  task automatic t_ptr;
    apb(1'b1, AFD_OFS_FLAGS, 32'h0a);
    apb(1'b1, AFD_OFS_PTR0, 32'h0ff);
    apb(1'b1, AFD_OFS_PTR1, 32'h100);
    apb(1'b1, AFD_OFS_PTR2, 32'h200);
    apb(1'b1, AFD_OFS_ACC, 32'h80);
    r = mk(AFD_OP_SWAP, AFD_AM_INDIRECT, 8'h00, 8'h00);
    r.to_source = 1'b1;
    r.vop = AFD_VP_POST_INC;
    go(r);
    chk("inc_addr", rsp.addr, 12'h0ff);
    apb(1'b0, AFD_OFS_PTR0, 32'h0);
    chk("inc_ptr", rd, 32'h100);
    r.ptr_idx = 2'h1;
    r.vop = AFD_VP_POST_DEC;
    go(r);
    apb(1'b0, AFD_OFS_PTR1, 32'h0);
    chk("dec_ptr", rd, 32'h0ff);
    r.ptr_idx = 2'h2;
    r.vop = AFD_VP_ACC_OFS;
    go(r);
    chk("ofs_addr", rsp.addr, 12'h180);
    apb(1'b0, AFD_OFS_PTR2, 32'h0);
    chk("ofs_ptr", rd, 32'h200);
    apb(1'b0, AFD_OFS_ACC, 32'h0);
    chk("ofs_acc", rd, 32'h80);
    chk("ptr_flags", flags, 8'h0a);
    r = mk(AFD_OP_SWAP, AFD_AM_DIRECT, AFD_OFFSET_MAX, 8'h00);
    r.to_source = 1'b1;
    go(r);
    chk("fuse_off", rsp.addr, 12'h05f);
    apb(1'b1, AFD_OFS_CFG, 32'h1);
    go(r);
    chk("fuse_on", rsp.addr, 12'h25f);
    r.literal = AFD_QUICK_SPLIT;
    go(r);
    chk("fuse_hi", rsp.addr, 12'hf60);
  endtask : t_ptr
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_regs;
    t_arith;
    t_flag_reg;
    t_addr;
    t_ptr;
    tally_and_finish;
  end
  // The tests need about 150 cycles; twenty times that means a hang
  initial
  begin
    repeat (3000) @(posedge clock);
    errors++;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
